// ---- src/uawk_pkg.sv ----
// Package of constants for the address-detect and wake-up qualifier
package uawk_pkg;
   // Register byte offsets
   localparam logic [7:0] CTRL_OFF   = 8'h00;
   localparam logic [7:0] STAT_OFF   = 8'h04;
   localparam logic [7:0] IRQ_ST_OFF = 8'h08;
   localparam logic [7:0] IRQ_MK_OFF = 8'h0C;
   localparam logic [7:0] COUNT_OFF  = 8'h10;
   // Control field positions
   localparam int CTL_ADDR_MATCH = 0;
   localparam int CTL_NINE_BIT   = 1;
   localparam int CTL_PARITY     = 2;
   localparam int CTL_UNIT_EN    = 3;
   localparam int CTL_RX_EN      = 4;
   localparam int CTL_RX_IRQ_EN  = 5;
   localparam int CTL_WAKE_EN    = 6;
   localparam int CTL_UART_IRQ   = 7;
   localparam int CTL_GLOBAL_IRQ = 8;
   localparam int CTL_WIDTH      = 9;
   // Event status bits
   localparam int EV_RX_DATA = 0;
   localparam int EV_ADDR    = 1;
   localparam int EV_WAKE    = 2;
   localparam int EV_WIDTH   = 3;
   // Reset values
   localparam logic [8:0] CTRL_RESET = 9'h000;
   localparam logic [2:0] MASK_RESET = 3'h7;
   // Recovery time after wake-up
   localparam int CLK_PERIOD_NS    = 10;
   localparam int RECOVERY_NS      = 1000;
   localparam int RECOVERY_CYCLES  = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Wake sequencer states
   typedef enum logic [1:0] {
      UAWK_RUN     = 2'b00,
      UAWK_ASLEEP  = 2'b01,
      UAWK_RECOVER = 2'b11
   } uawk_state_t;
endpackage

// ---- src/uawk_edge.sv ----
// Falling edge detector for the shared serial pin
`timescale 1ns/1ns
module uawk_edge (
   input  wire logic pclk,    // Clock
   input  wire logic presetn, // Async reset, active low
   input  wire logic enable,  // Detection enable
   input  wire logic pin,     // Pin level, synchronous
   output logic      fall     // One-cycle pulse on fall
);
   logic last;

   // Previous pin level, idle high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last <= 1'b1;
      end else begin
         last <= pin;
      end
   end

   assign fall = enable & last & ~pin;
endmodule

// ---- src/uawk_top.sv ----
// Receive qualifier, pause, and pin wake-up logic with APB registers
// How it works
// - address mode: interrupt only when top bit set
// - top bit is ninth or eighth bit
// - top bit high marks an address word
// - mode off: interrupt on every data flag
// - uart_irq needs uart and global enables; the irq output needs only status and mask
// - stopped clock freezes the shifter, wake logic keeps running
// - sleep during receive holds progress
// - sleep leaves all registers unchanged
// - pin fall while clock off wakes
// - data during recovery is discarded
// - enables clear: wake only, no interrupt
// - wake interrupt waits for recovery end
// - data flag tracks held bytes count
// - wake and address share the request
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ns
module uawk_top #(
   parameter int RECOVERY = uawk_pkg::RECOVERY_CYCLES // Recovery cycles
) (
   input  wire logic        pclk,          // Clock
   input  wire logic        presetn,       // Async reset, active low
   input  wire logic        psel,          // APB select
   input  wire logic        penable,       // APB enable
   input  wire logic        pwrite,        // APB direction
   input  wire logic [7:0]  paddr,         // APB address
   input  wire logic [31:0] pwdata,        // APB write data
   output logic      [31:0] prdata,        // APB read data
   output logic             pready,        // APB ready
   output logic             pslverr,       // APB error
   input  wire logic        uart_clk_on,   // UART clock running
   input  wire logic        core_sleep,    // Core idle or sleep
   input  wire logic        clock_stable,  // System clock recovered
   input  wire logic        rxtx_pin,      // Shared serial pin
   input  wire logic        word_done,     // Shifter finished a word
   input  wire logic [8:0]  word_data,     // Received word
   input  wire logic        data_pop,      // Data register read
   output logic             shifter_run,   // Shifter may advance
   output logic             rx_accept,     // Shifter input not discarded
   output logic             wake_request,  // Wake to clock controller
   output logic             uart_irq,      // Interrupt to processor
   output logic             rx_data_available_flag, // Data held
   output logic             address_word,  // Last word was an address
   output logic             irq            // Masked sticky status level
);
   logic [uawk_pkg::CTL_WIDTH-1:0] ctrl;
   logic [uawk_pkg::EV_WIDTH-1:0]  status;
   logic [uawk_pkg::EV_WIDTH-1:0]  mask;
   logic [uawk_pkg::EV_WIDTH-1:0]  next_events;
   logic [2:0]                     count;
   logic [15:0]                    rec_cnt;
   uawk_pkg::uawk_state_t          state;
   logic                           pin_fall;
   logic                           top_bit;
   logic                           rx_event;
   logic                           wake_pend;
   logic                           wr;
   logic                           rd_status;
   logic                           active;
   logic                           addr_mode;
   logic                           enables_ok;
   logic                           wake_armed;

   assign addr_mode = ctrl[uawk_pkg::CTL_ADDR_MATCH];
   assign enables_ok = ctrl[uawk_pkg::CTL_UART_IRQ] & ctrl[uawk_pkg::CTL_GLOBAL_IRQ];
   assign wake_armed = ctrl[uawk_pkg::CTL_WAKE_EN] & ctrl[uawk_pkg::CTL_UNIT_EN]
                     & ctrl[uawk_pkg::CTL_RX_EN] & ctrl[uawk_pkg::CTL_RX_IRQ_EN];

   // Shifter advances only with clock and awake core
   assign active = uart_clk_on & ~core_sleep & (state == uawk_pkg::UAWK_RUN);
   assign shifter_run = active;
   assign rx_accept   = state == uawk_pkg::UAWK_RUN;

   // Qualifying top bit selection
   assign top_bit = ctrl[uawk_pkg::CTL_NINE_BIT] ? word_data[8] : word_data[7];

   // Pin fall detector, only armed while clock off
   uawk_edge u_edge (
      .pclk    (pclk),
      .presetn (presetn),
      .enable  (wake_armed & ~uart_clk_on & (state == uawk_pkg::UAWK_ASLEEP)),
      .pin     (rxtx_pin),
      .fall    (pin_fall)
   );

   // Wake sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= uawk_pkg::UAWK_RUN;
      end else begin
         unique case (state)
            uawk_pkg::UAWK_RUN: begin
               if (!uart_clk_on) begin
                  state <= uawk_pkg::UAWK_ASLEEP;
               end
            end
            uawk_pkg::UAWK_ASLEEP: begin
               if (pin_fall) begin
                  state <= uawk_pkg::UAWK_RECOVER;
               end else if (uart_clk_on) begin
                  state <= uawk_pkg::UAWK_RUN;
               end
            end
            uawk_pkg::UAWK_RECOVER: begin
               if (clock_stable && rec_cnt == 16'(RECOVERY - 1) && uart_clk_on) begin
                  state <= uawk_pkg::UAWK_RUN;
               end
            end
            default: begin
               state <= uawk_pkg::UAWK_RUN;
            end
         endcase
      end
   end

   // Recovery counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rec_cnt <= 16'h0000;
      end else if (state != uawk_pkg::UAWK_RECOVER) begin
         rec_cnt <= 16'h0000;
      end else if (clock_stable && rec_cnt != 16'(RECOVERY - 1)) begin
         rec_cnt <= rec_cnt + 16'h0001;
      end
   end

   // Wake request held until recovery ends
   assign wake_request = state == uawk_pkg::UAWK_RECOVER;

   // Pending wake interrupt, delivered after recovery
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_pend <= 1'b0;
      end else if (pin_fall) begin
         wake_pend <= 1'b1;
      end else if (state == uawk_pkg::UAWK_RUN) begin
         wake_pend <= 1'b0;
      end
   end

   // Words count only while running and not discarded
   assign rx_event = word_done & active;

   // Held byte count, registers untouched by sleep
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= 3'h0;
      end else if (rx_event && !(data_pop && count != 3'h0)) begin
         if (count != 3'h4) begin
            count <= count + 3'h1;
         end
      end else if (data_pop && !rx_event && count != 3'h0) begin
         count <= count - 3'h1;
      end
   end
   assign rx_data_available_flag = count != 3'h0;

   // Address word marker
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         address_word <= 1'b0;
      end else if (rx_event) begin
         address_word <= addr_mode & top_bit;
      end
   end

   // Events this cycle
   always_comb begin
      next_events = '0;
      next_events[uawk_pkg::EV_RX_DATA] = rx_event & (~addr_mode | top_bit);
      next_events[uawk_pkg::EV_ADDR]    = rx_event & addr_mode & top_bit;
      next_events[uawk_pkg::EV_WAKE]    = wake_pend & (state == uawk_pkg::UAWK_RUN);
   end

   // Shared request needs source, uart and global enables
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         uart_irq <= 1'b0;
      end else begin
         uart_irq <= enables_ok & (
            (next_events[uawk_pkg::EV_RX_DATA] & ctrl[uawk_pkg::CTL_RX_IRQ_EN]) |
            next_events[uawk_pkg::EV_WAKE]);
      end
   end

   // APB strobes, zero wait states
   assign wr        = psel & penable & pwrite;
   assign rd_status = psel & ~pwrite;
   assign pready    = 1'b1;
   assign pslverr   = 1'b0;

   // Control and mask registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= uawk_pkg::CTRL_RESET;
         mask <= uawk_pkg::MASK_RESET;
      end else if (wr) begin
         if (paddr == uawk_pkg::CTRL_OFF) begin
            ctrl <= pwdata[uawk_pkg::CTL_WIDTH-1:0];
         end
         if (paddr == uawk_pkg::IRQ_MK_OFF) begin
            mask <= pwdata[uawk_pkg::EV_WIDTH-1:0];
         end
      end
   end

   // Sticky status, set wins over write-one clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= '0;
      end else if (wr && paddr == uawk_pkg::IRQ_ST_OFF) begin
         status <= (status & ~pwdata[uawk_pkg::EV_WIDTH-1:0]) | next_events;
      end else begin
         status <= status | next_events;
      end
   end
   assign irq = |(status & mask);

   // Read data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_status && !penable) begin
         unique case (paddr)
            uawk_pkg::CTRL_OFF:   prdata <= {23'h0, ctrl};
            uawk_pkg::STAT_OFF:   prdata <= {28'h0, address_word, state == uawk_pkg::UAWK_RECOVER,
                                             state == uawk_pkg::UAWK_ASLEEP,
                                             rx_data_available_flag};
            uawk_pkg::IRQ_ST_OFF: prdata <= {29'h0, status};
            uawk_pkg::IRQ_MK_OFF: prdata <= {29'h0, mask};
            uawk_pkg::COUNT_OFF:  prdata <= {29'h0, count};
            default:              prdata <= 32'h0000_0000;
         endcase
      end
   end

   // Checks
   top_bit_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      (rx_event && addr_mode && !top_bit) |-> !next_events[uawk_pkg::EV_RX_DATA])
      else $error("address mode passed data word");
   every_word_a: assert property (@(posedge pclk) disable iff (!presetn)
      (rx_event && !addr_mode) |=> status[uawk_pkg::EV_RX_DATA])
      else $error("data event lost");
   irq_enables_a: assert property (@(posedge pclk) disable iff (!presetn)
      uart_irq |-> $past(enables_ok))
      else $error("irq without enables");
   shifter_freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
      !uart_clk_on |-> !shifter_run)
      else $error("shifter runs without clock");
   recover_discard_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state == uawk_pkg::UAWK_RECOVER && word_done) |=> $stable(count))
      else $error("word kept during recovery");
   wake_enter_a: assert property (@(posedge pclk) disable iff (!presetn)
      pin_fall |=> state == uawk_pkg::UAWK_RECOVER)
      else $error("fall did not wake");
   wake_late_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state == uawk_pkg::UAWK_RECOVER) |-> !uart_irq)
      else $error("irq before recovery end");
   flag_count_a: assert property (@(posedge pclk) disable iff (!presetn)
      (rx_event && count == 3'h0 && !data_pop) |=> rx_data_available_flag)
      else $error("flag not set");
   nine_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
      (rx_event && addr_mode && ctrl[uawk_pkg::CTL_NINE_BIT])
         |-> next_events[uawk_pkg::EV_RX_DATA] == word_data[8])
      else $error("ninth bit not qualifying");
   eight_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
      (rx_event && addr_mode && !ctrl[uawk_pkg::CTL_NINE_BIT])
         |-> next_events[uawk_pkg::EV_RX_DATA] == word_data[7])
      else $error("eighth bit not qualifying");
   addr_word_a: assert property (@(posedge pclk) disable iff (!presetn)
      (rx_event && addr_mode && top_bit) |=> address_word && status[uawk_pkg::EV_ADDR])
      else $error("address word not marked");
   wake_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
      (next_events[uawk_pkg::EV_WAKE] && enables_ok) |=> uart_irq)
      else $error("wake interrupt lost");
   quiet_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
      (next_events[uawk_pkg::EV_WAKE] && !enables_ok) |=> !uart_irq)
      else $error("interrupt with enables clear");
   sleep_regs_a: assert property (@(posedge pclk) disable iff (!presetn)
      (core_sleep && !wr && !data_pop) |=> $stable(ctrl) && $stable(mask) && $stable(count))
      else $error("register changed in sleep");
   recover_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state == uawk_pkg::UAWK_RECOVER && !clock_stable) |=> state == uawk_pkg::UAWK_RECOVER)
      else $error("recovery ended without stable clock");
   clock_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!uart_clk_on && word_done && !data_pop) |=> $stable(count))
      else $error("word taken without clock");
   flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      (count == 3'h1 && data_pop && !rx_event) |=> !rx_data_available_flag)
      else $error("flag not cleared");

   // Scenario covers
   cv_addr_c: cover property (@(posedge pclk) disable iff (!presetn)
      rx_event && addr_mode && top_bit);
   cv_wake_c: cover property (@(posedge pclk) disable iff (!presetn)
      next_events[uawk_pkg::EV_WAKE] && enables_ok);
   cv_irq_c: cover property (@(posedge pclk) disable iff (!presetn) irq);
   cv_quiet_c: cover property (@(posedge pclk) disable iff (!presetn)
      next_events[uawk_pkg::EV_WAKE] && !enables_ok);
   cv_nine_c: cover property (@(posedge pclk) disable iff (!presetn)
      rx_event && addr_mode && ctrl[uawk_pkg::CTL_NINE_BIT] && word_data[8]);
endmodule

// ---- tb/uawk_link_model.sv ----
// Remote serial transmitter model on the shared pin and shifter side
`timescale 1ns/1ns
module uawk_link_model (
   input  wire logic       pclk,      // Clock
   output logic            rxtx_pin,  // Shared serial pin, idle high
   output logic            word_done, // Word finished pulse
   output logic      [8:0] word_data  // Received word
);
   // Idle line, no word pending
   initial begin
      rxtx_pin = 1'b1;
      word_done = 1'b0;
      word_data = 9'h000;
   end
   // Start bit, then one-cycle hand-over of the word
   task automatic send(input logic [8:0] w);
      @(posedge pclk);
      rxtx_pin <= 1'b0;
      repeat (2) @(posedge pclk);
      word_done <= 1'b1;
      word_data <= w;
      @(posedge pclk);
      word_done <= 1'b0;
      word_data <= ~w; // Word not held after the pulse
      rxtx_pin <= 1'b1;
   endtask
endmodule

// ---- tb/test_uart_address_detect_wakeup.sv ----
// Self-checking bench for the address-detect and wake-up qualifier
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin n_fail++; \
   $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module test_uart_address_detect_wakeup;
   localparam int REC = 4;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, data_pop;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, r;
   logic        uart_clk_on, core_sleep, clock_stable, rxtx_pin, word_done;
   logic [8:0]  word_data;
   logic        shifter_run, rx_accept, wake_request, uart_irq, rx_data_available_flag;
   logic        address_word, irq;
   int          n_fail, checks, n_irq, n0;
   uawk_top #(.RECOVERY(REC)) i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .uart_clk_on(uart_clk_on), .core_sleep(core_sleep), .clock_stable(clock_stable),
      .rxtx_pin(rxtx_pin), .word_done(word_done), .word_data(word_data), .data_pop(data_pop),
      .shifter_run(shifter_run), .rx_accept(rx_accept), .wake_request(wake_request),
      .uart_irq(uart_irq), .rx_data_available_flag(rx_data_available_flag),
      .address_word(address_word), .irq(irq)
   );
   uawk_link_model i_link (
      .pclk(pclk), .rxtx_pin(rxtx_pin), .word_done(word_done), .word_data(word_data)
   );
   // Clock and interrupt pulse counter
   always #5 pclk = ~pclk;
   always @(posedge pclk) begin
      if (uart_irq === 1'b1) n_irq <= n_irq + 1;
   end
   // Verdict and end of run
   task automatic end_of_test();
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // One APB transfer, read data taken at the ready edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int k;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
      q = prdata;
      {psel, penable} <= 2'b00;
      @(negedge pclk);
      if (pready !== 1'b1) begin n_fail++; end_of_test(); end
   endtask
   // Pulse of the data register read
   task automatic pop1();
      @(posedge pclk) data_pop <= 1'b1;
      @(posedge pclk) data_pop <= 1'b0;
   endtask
   // One received word, then its interrupt pulses counted
   task automatic word(input logic [8:0] w, input int exp, input logic pop);
      n0 = n_irq;
      i_link.send(w);
      repeat (3) @(negedge pclk);
      `CHK("uart_irq pulses", exp, n_irq - n0)
      if (pop) pop1();
   endtask
   // Clock off, pin fall, recovery, then the wake interrupt
   task automatic wake(input logic [31:0] c, input int exp);
      apb(1'b1, uawk_pkg::CTRL_OFF, c, r);
      apb(1'b1, uawk_pkg::IRQ_ST_OFF, 32'h0000_0007, r);
      @(posedge pclk);
      {uart_clk_on, clock_stable} <= 2'b00;
      repeat (2) @(negedge pclk);
      `CHK("shifter frozen", 1'b0, shifter_run)
      i_link.send(9'h000);
      @(negedge pclk);
      `CHK("wake request", 1'b1, wake_request)
      `CHK("rx discarded", 1'b0, rx_accept)
      i_link.send(9'h0AA);
      @(posedge pclk);
      {uart_clk_on, clock_stable} <= 2'b11;
      n0 = n_irq;
      repeat (REC + 1) @(negedge pclk);
      `CHK("early wake irq", 0, n_irq - n0)
      repeat (REC + 2) @(negedge pclk);
      `CHK("wake irq", exp, n_irq - n0)
      `CHK("rx accepted again", 1'b1, rx_accept)
      `CHK("wake request ended", 1'b0, wake_request)
      `CHK("no data kept", 1'b0, rx_data_available_flag)
      apb(1'b0, uawk_pkg::IRQ_ST_OFF, 32'h0, r);
      `CHK("wake status", 32'h0000_0004, r & 32'h0000_0004)
   endtask
   // Main sequence
   initial begin
      {psel, penable, pwrite, data_pop, core_sleep, presetn, pclk, paddr, pwdata} = '0;
      {uart_clk_on, clock_stable} = 2'b11;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, uawk_pkg::CTRL_OFF, 32'h0, r);
      `CHK("ctrl reset", 32'h0000_0000, r)
      apb(1'b0, uawk_pkg::IRQ_MK_OFF, 32'h0, r);
      `CHK("mask reset", 32'h0000_0007, r)
      apb(1'b1, 8'h40, 32'hFFFF_FFFF, r);
      apb(1'b0, 8'h40, 32'h0, r);
      `CHK("unmapped", 32'h0000_0000, r)
      `CHK("no slave error", 1'b0, pslverr)
      apb(1'b1, uawk_pkg::CTRL_OFF, 32'h0000_01B8, r);
      word(9'h000, 1, 1'b0);
      word(9'h080, 1, 1'b0);
      apb(1'b0, uawk_pkg::COUNT_OFF, 32'h0, r);
      `CHK("byte count", 32'h0000_0002, r)
      `CHK("data flag set", 1'b1, rx_data_available_flag)
      repeat (2) pop1();
      @(negedge pclk);
      `CHK("data flag clear", 1'b0, rx_data_available_flag)
      for (int nb = 0; nb < 2; nb++) begin
         for (int t = 0; t < 2; t++) begin
            apb(1'b1, uawk_pkg::CTRL_OFF, 32'h0000_01B9 | 32'(nb << 1), r);
            word(nb ? (t ? 9'h100 : 9'h0FF) : (t ? 9'h080 : 9'h07F), t, 1'b1);
            `CHK("address word", 1'(t), address_word)
         end
      end
      apb(1'b0, uawk_pkg::IRQ_ST_OFF, 32'h0, r);
      `CHK("data and address status", 32'h0000_0003, r)
      apb(1'b0, uawk_pkg::STAT_OFF, 32'h0, r);
      `CHK("status register", 32'h0000_0008, r)
      apb(1'b1, uawk_pkg::IRQ_ST_OFF, 32'h0000_0007, r);
      apb(1'b1, uawk_pkg::IRQ_MK_OFF, 32'h0000_0000, r);
      apb(1'b1, uawk_pkg::CTRL_OFF, 32'h0000_00B8, r);
      word(9'h080, 0, 1'b1);
      `CHK("irq masked", 1'b0, irq)
      apb(1'b1, uawk_pkg::IRQ_MK_OFF, 32'h0000_0007, r);
      `CHK("irq unmasked", 1'b1, irq)
      apb(1'b1, uawk_pkg::IRQ_ST_OFF, 32'h0000_0007, r);
      `CHK("irq cleared", 1'b0, irq)
      @(posedge pclk) core_sleep <= 1'b1;
      @(negedge pclk);
      `CHK("sleep holds shifter", 1'b0, shifter_run)
      apb(1'b0, uawk_pkg::CTRL_OFF, 32'h0, r);
      `CHK("ctrl kept", 32'h0000_00B8, r)
      @(posedge pclk) core_sleep <= 1'b0;
      wake(32'h0000_01F8, 1);
      wake(32'h0000_0078, 0);
      end_of_test();
   end
endmodule
